// >>> design/cis_entry_mem.sv
// memory holding the per-channel entries, registered read port
`default_nettype none
module cis_entry_mem
    import cis_pkg::*;
#(
    parameter int unsigned DEPTH = NUM_CHAN,
    parameter int unsigned AW = 4
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [ENTRY_W-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [ENTRY_W-1:0] rd_data_out
);
    // refuse a depth that the address cannot reach
    if (DEPTH > (1 << AW)) begin : g_depth_chk
        $error("depth exceeds address range");
    end
    logic [ENTRY_W-1:0] mem_q [DEPTH];
    // reset gives channel 0 enabled, all fields cleared otherwise
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= (i == 0) ? ENTRY0_RST : ENTRYM_RST;
            end
            rd_data_out <= ENTRYM_RST;
        end else begin
            if (wr_en_in) begin
                mem_q[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem_q[rd_addr_in];
        end
    end
endmodule // cis_entry_mem
`default_nettype wire

// >>> design/cis_pkg.sv
// package: register map, field layout and constants for the channel input switch config block
//------------------------------------------------------------------------------
// Overview of operation
// - sink switch closes while active channel bit set
// - power-down forces the sink switch open
// - standby opens switch unless keep bit set
// - sink switch bits reset to zero
// - channels with the limit bit set compare results against limits
// - no limit compare while fifo disabled
// - five-bit positive selector per channel, reset zero
// - external input codes map to inputs 0-7
// - internal source codes map to internal signals
// - enabled channels sequence ascending, wrap, tag nibble
//------------------------------------------------------------------------------
`default_nettype none
package cis_pkg;
    localparam int unsigned NUM_CHAN = 16;
    localparam int unsigned ENTRY_W = 24;
    // field positions inside one channel entry
    localparam int unsigned ENABLE_BIT = 23;
    localparam int unsigned SINK_BIT = 19;
    localparam int unsigned LIMIT_BIT = 18;
    localparam int unsigned POS_HI = 17;
    localparam int unsigned POS_LO = 13;
    localparam logic [ENTRY_W-1:0] ENTRY0_RST = 24'h80_0000;
    localparam logic [ENTRY_W-1:0] ENTRYM_RST = 24'h00_0000;
    // control registers (entries sit at CHAN_BASE + 4*m)
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_LIMIT = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFS_RESULT = 12'h014;
    localparam logic [11:0] CHAN_BASE = 12'h040;
    // ctrl bits
    localparam int unsigned CTRL_PDOWN = 0;
    localparam int unsigned CTRL_STBY = 1;
    localparam int unsigned CTRL_KEEP = 2;
    localparam int unsigned CTRL_FIFO = 3;
    // irq bits
    localparam int unsigned IRQ_LOW = 0;
    localparam int unsigned IRQ_HIGH = 1;
    localparam int unsigned IRQ_DONE = 2;
    localparam int unsigned IRQ_W = 3;
    // positive selector decode: one-hot route to the input multiplexer
    localparam int unsigned ROUTE_W = 13;
    typedef struct packed {
        logic [ROUTE_W-1:0] route;   // 0..7 ext inputs, 8 temp, 9 nsup, 10 ref, 11 gnd, 12 mon
        logic sink;
        logic limit_chk;
    } cis_apply_t;
endpackage : cis_pkg
`default_nettype wire

// >>> design/cis_top.sv
// channel input switch configuration: apb registers, sequencer, switch, limit check
//
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
module cis_top
    import cis_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done_in,         // one-cycle pulse, same clock
    input wire logic [23:0] conv_data_in,
    output logic sink_switch_pin_out,      // high closes switch to neg supply
    output logic [ROUTE_W-1:0] pos_route_out,
    output logic [3:0] active_chan_out,
    output logic irq_out
);
    //--------------------------------------------------------------------------
    // decode functions
    //--------------------------------------------------------------------------
    function automatic logic [ROUTE_W-1:0] decode_pos(input logic [4:0] code);
        logic [ROUTE_W-1:0] r;
        r = '0;
        case (code)
            5'h00: r[0] = 1'b1;
            5'h01: r[1] = 1'b1;
            5'h04: r[2] = 1'b1;
            5'h05: r[3] = 1'b1;
            5'h0A: r[4] = 1'b1;
            5'h0B: r[5] = 1'b1;
            5'h0E: r[6] = 1'b1;
            5'h0F: r[7] = 1'b1;
            5'h10: r[8] = 1'b1;
            5'h11: r[9] = 1'b1;
            5'h12: r[10] = 1'b1;
            5'h13: r[11] = 1'b1;
            5'h14: r[12] = 1'b1;
            default: r = '0; // reserved leaves input open
        endcase
        return r;
    endfunction

    function automatic logic is_chan(input logic [11:0] a);
        return (a >= CHAN_BASE) && (a < CHAN_BASE + 12'(NUM_CHAN * 4));
    endfunction

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_FETCH = 2'b01,
        SQ_RUN = 2'b11
    } cis_seq_t;

    typedef struct packed {
        logic [3:0] ctrl;
        logic [23:0] lim_low;
        logic [23:0] lim_high;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [23:0] result;
        logic [3:0] res_chan;
        cis_seq_t seq;
        logic [3:0] chan;
        logic [3:0] scan;
        cis_apply_t apply;
        logic [31:0] rdata;
        logic rd_mem;
    } cis_state_t;

    cis_state_t s_q, s_d;
    logic mem_we;
    logic [3:0] mem_addr;
    logic [ENTRY_W-1:0] mem_rd;
    logic acc;
    logic [ENTRY_W-1:0] fetched;
    logic sw_allow;
    logic below, above;

    assign acc = psel & penable;
    // memory reads use one extra cycle, so pready waits one cycle for entries
    assign pready = ~(acc & ~pwrite & is_chan(paddr) & ~s_q.rd_mem);
    assign pslverr = 1'b0;
    assign mem_we = acc & pwrite & is_chan(paddr);
    assign mem_addr = (psel & is_chan(paddr)) ? paddr[5:2] : s_q.scan;
    assign fetched = mem_rd;
    assign prdata = s_q.rdata;

    cis_entry_mem #(
        .DEPTH(NUM_CHAN),
        .AW(4)
    ) u_mem (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(mem_we),
        .wr_addr_in(paddr[5:2]),
        .wr_data_in(pwdata[ENTRY_W-1:0]),
        .rd_addr_in(mem_addr),
        .rd_data_out(mem_rd)
    );

    // switch gating by power mode
    assign sw_allow = ~s_q.ctrl[CTRL_PDOWN]
        & (~s_q.ctrl[CTRL_STBY] | s_q.ctrl[CTRL_KEEP]);
    assign sink_switch_pin_out = s_q.apply.sink & sw_allow;
    assign pos_route_out = s_q.apply.route;
    assign active_chan_out = s_q.chan;
    assign irq_out = |(s_q.irq_stat & s_q.irq_mask);
    assign below = $signed(conv_data_in) < $signed(s_q.lim_low);
    assign above = $signed(conv_data_in) > $signed(s_q.lim_high);

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb begin
        logic [IRQ_W-1:0] ev;
        ev = '0;
        s_d = s_q;
        s_d.rd_mem = 1'b0;
        // register writes
        if (acc & pwrite) begin
            case (paddr)
                OFS_CTRL: s_d.ctrl = pwdata[3:0];
                OFS_LIMIT: s_d.lim_low = pwdata[23:0];
                OFS_STATUS: s_d.lim_high = pwdata[23:0];
                OFS_IRQ_MASK: s_d.irq_mask = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // control reads load in the setup cycle, so prdata already stands
        // in the zero-wait access cycle while still coming from a flip-flop
        if (psel & ~penable & ~pwrite & ~is_chan(paddr)) begin
            case (paddr)
                OFS_CTRL: s_d.rdata = {28'h000_0000, s_q.ctrl};
                OFS_LIMIT: s_d.rdata = {8'h00, s_q.lim_low};
                OFS_STATUS: s_d.rdata = {8'h00, s_q.lim_high};
                OFS_IRQ_STAT: s_d.rdata = {29'h000_0000, s_q.irq_stat};
                OFS_IRQ_MASK: s_d.rdata = {29'h000_0000, s_q.irq_mask};
                OFS_RESULT: s_d.rdata = {4'h0, s_q.res_chan, s_q.result};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        // entry reads take the memory's registered output, one wait state
        if (acc & ~pwrite & is_chan(paddr)) begin
            s_d.rd_mem = ~s_q.rd_mem;
            s_d.rdata = {8'h00, fetched};
        end
        // sequencer: scan upward from the channel after the current one
        case (s_q.seq)
            SQ_IDLE: begin
                if (~(psel & is_chan(paddr)) & ~s_q.ctrl[CTRL_PDOWN]) begin
                    s_d.seq = SQ_FETCH;
                end
            end
            SQ_FETCH: begin
                // memory output now holds entry at scan
                if (psel & is_chan(paddr)) begin
                    s_d.seq = SQ_IDLE;
                end else if (fetched[ENABLE_BIT]) begin
                    s_d.chan = s_q.scan;
                    s_d.apply.sink = fetched[SINK_BIT];
                    s_d.apply.limit_chk = fetched[LIMIT_BIT];
                    s_d.apply.route = decode_pos(fetched[POS_HI:POS_LO]);
                    s_d.seq = SQ_RUN;
                end else begin
                    s_d.scan = s_q.scan + 4'h1; // ascending, wraps at 15
                    s_d.seq = SQ_IDLE;
                end
            end
            SQ_RUN: begin
                if (conv_done_in) begin
                    s_d.result = conv_data_in;
                    s_d.res_chan = s_q.chan;
                    ev[IRQ_DONE] = 1'b1;
                    if (s_q.apply.limit_chk & s_q.ctrl[CTRL_FIFO]) begin
                        ev[IRQ_LOW] = below;
                        ev[IRQ_HIGH] = above;
                    end
                    s_d.scan = s_q.chan + 4'h1;
                    s_d.seq = SQ_IDLE;
                end
            end
            default: s_d.seq = SQ_IDLE;
        endcase
        // sticky status: write one clears, a new event wins
        if (acc & pwrite & (paddr == OFS_IRQ_STAT)) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '{ctrl: 4'h0, lim_low: 24'h00_0000, lim_high: 24'h00_0000,
                     irq_stat: '0, irq_mask: '0, result: 24'h00_0000, res_chan: 4'h0,
                     seq: SQ_IDLE, chan: 4'h0, scan: 4'h0,
                     apply: '{route: '0, sink: 1'b0, limit_chk: 1'b0},
                     rdata: 32'h0000_0000, rd_mem: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    // an enabled entry is picked up by a fetch that no bus access cuts short
    sequence seq_apply;
        s_q.seq == SQ_FETCH && fetched[ENABLE_BIT] && !psel;
    endsequence
    // a conversion finishes while its channel is applied
    sequence seq_result;
        s_q.seq == SQ_RUN && conv_done_in;
    endsequence

    AST_PDOWN_OPEN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        s_q.ctrl[CTRL_PDOWN] |-> !sink_switch_pin_out) else $error("switch closed in power-down");
    AST_STBY_OPEN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (s_q.ctrl[CTRL_STBY] && !s_q.ctrl[CTRL_KEEP]) |-> !sink_switch_pin_out)
        else $error("switch closed in standby");
    AST_SINK_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_apply ##0 sw_allow
        |=> sink_switch_pin_out == $past(fetched[SINK_BIT])) else $error("switch mismatch");
    // a clear may drop bits with the fifo off, but no limit bit may rise
    AST_NO_LIMIT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_result ##0 (!s_q.ctrl[CTRL_FIFO])
        |=> (s_q.irq_stat[1:0] & ~$past(s_q.irq_stat[1:0])) == 2'b00)
        else $error("limit event with fifo off");
    AST_TAG: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_result |=> s_q.res_chan == $past(s_q.chan))
        else $error("result channel tag wrong");
    AST_DONE_EV: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_result |=> s_q.irq_stat[IRQ_DONE]) else $error("result event missed");
    AST_ROUTE_ONEHOT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        $onehot0(pos_route_out)) else $error("route not one-hot");
    AST_HIGH_EV: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_result ##0 (s_q.apply.limit_chk && s_q.ctrl[CTRL_FIFO] && above)
        |=> s_q.irq_stat[IRQ_HIGH]) else $error("high crossing missed");
    AST_LOW_EV: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_result ##0 (s_q.apply.limit_chk && s_q.ctrl[CTRL_FIFO] && below)
        |=> s_q.irq_stat[IRQ_LOW]) else $error("low crossing missed");
    AST_TEMP_ROUTE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        seq_apply ##0 (fetched[POS_HI:POS_LO] == 5'h10)
        |=> pos_route_out[8]) else $error("temp route");
    // control read data must already stand in the zero-wait access cycle
    AST_CTRL_READ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (psel && !penable && !pwrite && paddr == OFS_CTRL)
        |=> prdata == {28'h000_0000, $past(s_q.ctrl)}) else $error("control read late");
endmodule // cis_top
`default_nettype wire

// >>> verif/cis_conv_model.sv
// converter stand-in: answers a start request with one result pulse
`default_nettype none
module cis_conv_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [7:0] delay_in,
    input wire logic [23:0] value_in,
    output logic done_out,
    output logic [23:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic [7:0] cnt_q;
    logic [23:0] held_q;
    //--------------------------------------------------------------------------
    // result timing
    //--------------------------------------------------------------------------
    // outside the pulse the data bus toggles, so a stale value never looks valid
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            held_q <= 24'h00_0000;
            done_out <= 1'b0;
            data_out <= 24'h00_0000;
        end else begin
            done_out <= 1'b0;
            data_out <= ~data_out;
            if (start_in && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q <= delay_in;
                held_q <= value_in;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q <= 1'b0;
                done_out <= 1'b1;
                data_out <= held_q;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule // cis_conv_model
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the channel input switch configuration block
`default_nettype none
module testbench
    import cis_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic slverr;
    logic start = 1'b0;
    logic [7:0] dly = 8'h00;
    logic [23:0] cval = 24'h00_0000;
    logic done;
    logic [23:0] cdata;
    logic pin;
    logic [ROUTE_W-1:0] route;
    logic [3:0] chan;
    logic irq;
    logic [31:0] rd;
    int n_fail = 0;
    int checked = 0;
    logic [4:0] codes [13] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
    logic [31:0] ctrls [4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0006, 32'h0000_0000};
    logic pins [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    cis_top u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(slverr), .conv_done_in(done), .conv_data_in(cdata),
        .sink_switch_pin_out(pin), .pos_route_out(route), .active_chan_out(chan),
        .irq_out(irq));
    cis_conv_model u_conv (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .start_in(start),
        .delay_in(dly), .value_in(cval), .done_out(done), .data_out(cdata));
    //--------------------------------------------------------------------------
    // clock and tasks
    //--------------------------------------------------------------------------
    // free-running 40 MHz clock
    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    // ports are looked at on the falling edge, well away from any update
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; pready is judged at the rising edge, where the
    // request still stands, and only the watchdog ends a wait that never ends
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, exp);
    endtask
    // one result, then time for the sequencer to scan all entries again
    task automatic convert(input logic [23:0] v, input logic [7:0] d);
        @(posedge sys_clk_in);
        cval <= v;
        dly <= d;
        start <= 1'b1;
        @(posedge sys_clk_in);
        start <= 1'b0;
        cyc(int'(d) + 40);
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    //--------------------------------------------------------------------------
    // tests
    //--------------------------------------------------------------------------
    // hang guard: all tests need well under 6000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rchk(CHAN_BASE, 32'h0080_0000, 32'hFFFF_FFFF);
        rchk(CHAN_BASE + 12'h004, 32'h0000_0000, 32'hFFFF_FFFF);
        rchk(12'hFFC, 32'h0000_0000, 32'hFFFF_FFFF);
        chk({31'h0, slverr}, 32'h0000_0000);
        chk({31'h0, pin}, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            wr(CHAN_BASE, {8'h00, 4'h8, 1'b1, 1'b0, codes[i], 13'h0000});
            rchk(CHAN_BASE, {8'h00, 4'h8, 1'b1, 1'b0, codes[i], 13'h0000}, 32'hFFFF_FFFF);
            convert(24'h00_0000, i[0] ? 8'd1 : 8'd25);
            chk({19'h0, route}, 32'h0000_0001 << i);
            chk({31'h0, pin}, 32'h0000_0001);
        end
        $display("test selector done");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, ctrls[i]);
            cyc(3);
            chk({31'h0, pin}, {31'h0, pins[i]});
        end
        wr(CHAN_BASE, 32'h0080_0000);
        convert(24'h00_0000, 8'd2);
        chk({31'h0, pin}, 32'h0000_0000);
        $display("test switch done");
        wr(OFS_LIMIT, 32'h0000_0100);
        wr(OFS_STATUS, 32'h0000_0F00);
        wr(OFS_IRQ_MASK, 32'h0000_0003);
        wr(CHAN_BASE, 32'h0084_0000);
        convert(24'h00_0000, 8'd2);
        wr(OFS_IRQ_STAT, 32'h0000_0007);
        convert(24'h00_0010, 8'd2);
        rchk(OFS_IRQ_STAT, 32'h0000_0000, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0008);
        convert(24'h00_0010, 8'd2);
        rchk(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        cyc(0);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0000_0003);
        wr(OFS_IRQ_STAT, 32'h0000_0001);
        cyc(0);
        chk({31'h0, irq}, 32'h0000_0000);
        convert(24'hFF_FFF0, 8'd3);
        rchk(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0003);
        wr(OFS_IRQ_STAT, 32'h0000_0003);
        convert(24'h00_1000, 8'd3);
        rchk(OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0003);
        rchk(OFS_RESULT, 32'h0000_1000, 32'hFFFF_FFFF);
        $display("test limits done");
        wr(CHAN_BASE + 12'h008, 32'h0081_4000);
        convert(24'h00_0123, 8'd1);
        chk({28'h0, chan}, 32'h0000_0002);
        chk({19'h0, route}, 32'h0000_0010);
        convert(24'h00_0456, 8'd1);
        rchk(OFS_RESULT, 32'h0200_0456, 32'hFFFF_FFFF);
        chk({28'h0, chan}, 32'h0000_0000);
        $display("test sequence done");
        // a second reset in mid-run must bring every entry back to its default
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rchk(CHAN_BASE + 12'h008, 32'h0000_0000, 32'hFFFF_FFFF);
        rchk(CHAN_BASE, 32'h0080_0000, 32'hFFFF_FFFF);
        rchk(OFS_IRQ_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
        chk({31'h0, pin}, 32'h0000_0000);
        $display("test second reset done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
